/* File: rtl/uotgsr_pkg.sv */
package uotgsr_pkg;
  // Byte offsets within the block's AXI window
  localparam logic [11:0] OFS_LINE_STATUS = 12'h604;
  localparam logic [11:0] OFS_PULL_CONTROL = 12'h606;
  localparam logic [11:0] OFS_POWER_CONTROL = 12'h608;
  localparam logic [11:0] OFS_GEN_IRQ_STATUS = 12'h60a;
  localparam logic [11:0] OFS_GEN_IRQ_ENABLE = 12'h60c;
  localparam logic [11:0] OFS_ERROR_FLAG_STATUS = 12'h60e;
  localparam logic [11:0] OFS_ERROR_FLAG_ENABLE = 12'h610;
  localparam logic [11:0] OFS_LAST_XFER_STATUS = 12'h612;
  localparam logic [11:0] OFS_ROLE_CONTROL = 12'h614;
  localparam int REG_INDEX_SHIFT = 1;

  // Error flag positions
  localparam int ERR_STUFF = 7;
  localparam int ERR_OVERRUN = 5;
  localparam int ERR_TURNAROUND = 4;
  localparam int ERR_PARTIAL = 3;
  localparam int ERR_DATA_CRC = 2;
  localparam int ERR_TOKEN_OR_EOF = 1;
  localparam int ERR_PID = 0;
  localparam logic [7:0] ERR_IMPL_MASK = 8'hbf;

  // General interrupt positions
  localparam int GIRQ_TOKEN_DONE = 3;
  localparam int GIRQ_FRAME_START = 2;
  localparam int GIRQ_SUMMARY_ERR = 1;
  localparam int GIRQ_RESET_DETACH = 0;
  localparam logic [7:0] GIRQ_IMPL_MASK = 8'h0f;

  // Pull control positions
  localparam int PC_DP_UP = 7;
  localparam int PC_DM_UP = 6;
  localparam int PC_DP_DN = 5;
  localparam int PC_DM_DN = 4;
  localparam int PC_DUAL_ROLE = 2;
  localparam int PC_DISCHARGE = 0;
  localparam logic [7:0] PC_IMPL_MASK = 8'hf5;

  // Power control positions
  localparam int PW_ACT_PEND = 7;
  localparam int PW_SLEEP_GUARD = 4;
  localparam int PW_SUSPEND = 1;
  localparam int PW_MOD_POWER = 0;

  // Role control positions
  localparam int RC_HOST = 3;
  localparam int RC_MODULE = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int LINE_STEADY_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINE_STEADY_CYCLES = LINE_STEADY_NS / CLK_PERIOD_NS;
  localparam int XFER_QUEUE_DEPTH = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic stuff;
    logic overrun;
    logic turnaround;
    logic partial;
    logic data_crc;
    logic token_crc;
    logic frame_end;
    logic pid;
  } uotgsr_err_ev_s;

  typedef struct packed {
    logic [3:0] endpoint;
    logic tx;
    logic odd;
  } uotgsr_xfer_s;

  typedef struct packed {
    logic cable_ident;
    logic session_valid;
    logic session_end;
    logic vbus_valid;
    logic line_se0;
    logic line_j;
  } uotgsr_phy_s;

  typedef struct packed {
    logic plus_line_pullup_en;
    logic minus_line_pullup_en;
    logic plus_line_pulldown_en;
    logic minus_line_pulldown_en;
    logic bus_voltage_discharge_en;
  } uotgsr_pull_s;

  typedef enum logic [1:0] {
    UOTGSR_WIDLE = 2'b01,
    UOTGSR_WRESP = 2'b10
  } uotgsr_wstate_e;
endpackage

/* File: rtl/uotgsr_regs.sv */
module uotgsr_regs
  import uotgsr_pkg::*;
#(
  parameter int STEADY_CYCLES = LINE_STEADY_CYCLES,
  parameter int QUEUE_DEPTH = XFER_QUEUE_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uotgsr_err_ev_s err_ev,
  input wire logic frame_start_ev,
  input wire logic bus_reset_ev,
  input wire logic detach_ev,
  input wire logic xfer_done,
  input wire uotgsr_xfer_s xfer_info,
  output logic xfer_ready,
  input wire uotgsr_phy_s phy,
  input wire logic activity_busy,
  input wire logic suspend_hw_clear,
  output uotgsr_pull_s pulls,
  output logic usb_clk_gate,
  output logic xcvr_low_power,
  output logic module_power_enable,
  output logic host_role_enable,
  output logic module_enable,
  output logic [7:0] gen_irq_status
);
  localparam int QW = $clog2(QUEUE_DEPTH);
  localparam int SW = $clog2(STEADY_CYCLES + 1);

  uotgsr_wstate_e wstate_reg;
  logic [11:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic [7:0] err_flag_reg;
  logic [7:0] err_en_reg;
  logic [7:0] gen_en_reg;
  logic [7:0] gen_flag_reg;
  logic [7:0] pull_ctl_reg;
  logic sleep_guard_reg;
  logic suspend_reg;
  logic power_reg;
  logic [7:0] role_reg;
  logic [1:0] line_prev_reg;
  logic [SW-1:0] steady_cnt_reg;
  uotgsr_xfer_s queue_mem [QUEUE_DEPTH];
  logic [QW-1:0] q_rd_reg;
  logic [QW-1:0] q_wr_reg;
  logic [QW:0] q_cnt_reg;

  logic wr_fire;
  logic [15:0] wr_data;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic [7:0] gen_set;
  logic [7:0] gen_clr;
  logic q_pop;
  logic q_push;
  logic line_steady;
  logic host_mode;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a[11:2] == ofs[11:2] && a[1] == ofs[1];
  endfunction

  // Halfword registers share a word; only the addressed halfword's low byte lane counts
  function automatic logic lanes_ok(input logic [11:0] a, input logic [3:0] strb);
    return a[1] ? strb[2] : strb[0];
  endfunction

  assign host_mode = role_reg[RC_HOST];
  assign host_role_enable = role_reg[RC_HOST];
  assign module_enable = role_reg[RC_MODULE];
  assign module_power_enable = power_reg;
  assign s_axi_awready = wstate_reg == UOTGSR_WIDLE && !aw_held_reg;
  assign s_axi_wready = wstate_reg == UOTGSR_WIDLE && !w_held_reg;
  assign wr_fire = wstate_reg == UOTGSR_WIDLE && aw_held_reg && w_held_reg;
  assign wr_data = awaddr_reg[1] ? wdata_reg[31:16] : wdata_reg[15:0];

  // Whole word and lanes kept: data may arrive before its address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  logic wr_known;
  logic wr_en;
  assign wr_known = hit(awaddr_reg, OFS_LINE_STATUS) || hit(awaddr_reg, OFS_PULL_CONTROL)
                 || hit(awaddr_reg, OFS_POWER_CONTROL) || hit(awaddr_reg, OFS_GEN_IRQ_STATUS)
                 || hit(awaddr_reg, OFS_GEN_IRQ_ENABLE) || hit(awaddr_reg, OFS_ERROR_FLAG_STATUS)
                 || hit(awaddr_reg, OFS_ERROR_FLAG_ENABLE) || hit(awaddr_reg, OFS_LAST_XFER_STATUS)
                 || hit(awaddr_reg, OFS_ROLE_CONTROL);
  assign wr_en = wr_fire && wr_known && lanes_ok(awaddr_reg, wstrb_reg);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wstate_reg <= UOTGSR_WIDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      unique case (wstate_reg)
        UOTGSR_WIDLE: begin
          if (wr_fire) begin
            wstate_reg <= UOTGSR_WRESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
          end
        end
        UOTGSR_WRESP: begin
          if (s_axi_bready) begin
            wstate_reg <= UOTGSR_WIDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Error flags: write of ones clears those positions; an event in the same cycle keeps its flag set
  always_comb begin
    err_set = 8'h00;
    err_set[ERR_STUFF] = err_ev.stuff;
    err_set[ERR_OVERRUN] = err_ev.overrun;
    err_set[ERR_TURNAROUND] = err_ev.turnaround;
    err_set[ERR_PARTIAL] = err_ev.partial;
    err_set[ERR_DATA_CRC] = err_ev.data_crc;
    err_set[ERR_PID] = err_ev.pid;
    err_set[ERR_TOKEN_OR_EOF] = host_mode ? err_ev.frame_end
                                          : err_ev.token_crc;
    err_clr = wr_en && hit(awaddr_reg, OFS_ERROR_FLAG_STATUS) ? wr_data[7:0] : 8'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_flag_reg <= RESET_BYTE;
    end else begin
      err_flag_reg <= ((err_flag_reg & ~err_clr) | err_set) & ERR_IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_en_reg <= RESET_BYTE;
      gen_en_reg <= RESET_BYTE;
      pull_ctl_reg <= RESET_BYTE;
      role_reg <= RESET_BYTE;
    end else if (wr_en) begin
      if (hit(awaddr_reg, OFS_ERROR_FLAG_ENABLE))
        err_en_reg <= wr_data[7:0] & ERR_IMPL_MASK;
      if (hit(awaddr_reg, OFS_GEN_IRQ_ENABLE))
        gen_en_reg <= wr_data[7:0] & GIRQ_IMPL_MASK;
      if (hit(awaddr_reg, OFS_PULL_CONTROL))
        pull_ctl_reg <= wr_data[7:0] & PC_IMPL_MASK;
      if (hit(awaddr_reg, OFS_ROLE_CONTROL)) begin
        role_reg[RC_HOST] <= wr_data[RC_HOST];
        role_reg[RC_MODULE] <= wr_data[RC_MODULE];
      end
    end
  end

  // General flags; only enabled errors raise the summary flag
  always_comb begin
    gen_set = 8'h00;
    gen_set[GIRQ_TOKEN_DONE] = q_push || q_cnt_reg > (QW + 1)'(q_pop);
    gen_set[GIRQ_FRAME_START] = frame_start_ev;
    gen_set[GIRQ_SUMMARY_ERR] = |(err_set & err_en_reg);
    gen_set[GIRQ_RESET_DETACH] = host_mode ? detach_ev : bus_reset_ev;
    gen_clr = wr_en && hit(awaddr_reg, OFS_GEN_IRQ_STATUS) ? wr_data[7:0] : 8'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_flag_reg <= RESET_BYTE;
    end else begin
      gen_flag_reg <= ((gen_flag_reg & ~gen_clr) | gen_set) & GIRQ_IMPL_MASK;
    end
  end
  assign gen_irq_status = gen_flag_reg & gen_en_reg;

  // Completed-transfer queue; engine stalls on xfer_ready when full
  assign q_pop = gen_clr[GIRQ_TOKEN_DONE] && q_cnt_reg != '0;
  assign xfer_ready = q_cnt_reg != (QW + 1)'(QUEUE_DEPTH);
  assign q_push = xfer_done && xfer_ready;

  always_ff @(posedge clk) begin
    if (q_push)
      queue_mem[q_wr_reg] <= xfer_info;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_rd_reg <= '0;
      q_wr_reg <= '0;
      q_cnt_reg <= '0;
    end else begin
      if (q_push)
        q_wr_reg <= q_wr_reg + 1'b1;
      if (q_pop)
        q_rd_reg <= q_rd_reg + 1'b1;
      q_cnt_reg <= q_cnt_reg + (QW + 1)'(q_push) - (QW + 1)'(q_pop);
    end
  end

  // Power control; hardware clear of suspend beats software set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_guard_reg <= 1'b0;
      suspend_reg <= 1'b0;
      power_reg <= 1'b0;
    end else begin
      if (wr_en && hit(awaddr_reg, OFS_POWER_CONTROL)) begin
        sleep_guard_reg <= wr_data[PW_SLEEP_GUARD];
        power_reg <= wr_data[PW_MOD_POWER];
        suspend_reg <= wr_data[PW_SUSPEND] && !suspend_hw_clear;
      end else if (suspend_hw_clear) begin
        suspend_reg <= 1'b0;
      end
    end
  end
  assign usb_clk_gate = suspend_reg;
  assign xcvr_low_power = suspend_reg;

  // Line steadiness over SE0 and J
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_prev_reg <= 2'b00;
      steady_cnt_reg <= '0;
    end else begin
      line_prev_reg <= {phy.line_se0, phy.line_j};
      if ({phy.line_se0, phy.line_j} != line_prev_reg)
        steady_cnt_reg <= '0;
      else if (steady_cnt_reg != SW'(STEADY_CYCLES))
        steady_cnt_reg <= steady_cnt_reg + 1'b1;
    end
  end
  assign line_steady = steady_cnt_reg == SW'(STEADY_CYCLES);

  // Resistor steering
  always_comb begin
    if (pull_ctl_reg[PC_DUAL_ROLE]) begin
      pulls.plus_line_pullup_en = pull_ctl_reg[PC_DP_UP];
      pulls.minus_line_pullup_en = pull_ctl_reg[PC_DM_UP];
      pulls.plus_line_pulldown_en = pull_ctl_reg[PC_DP_DN];
      pulls.minus_line_pulldown_en = pull_ctl_reg[PC_DM_DN];
    end else begin
      pulls.plus_line_pullup_en = module_enable && !host_mode;
      pulls.minus_line_pullup_en = 1'b0;
      pulls.plus_line_pulldown_en = host_mode;
      pulls.minus_line_pulldown_en = host_mode;
    end
    pulls.bus_voltage_discharge_en = pull_ctl_reg[PC_DISCHARGE];
  end

  // Read channel: one-cycle answer, read has no side effects
  logic [7:0] rd_byte;
  logic rd_known;
  uotgsr_xfer_s q_head;
  assign q_head = q_cnt_reg != '0 ? queue_mem[q_rd_reg] : '0;

  always_comb begin
    rd_byte = 8'h00;
    rd_known = 1'b1;
    if (hit(s_axi_araddr, OFS_LINE_STATUS))
      rd_byte = {phy.cable_ident, 1'b0, line_steady, 1'b0,
                 phy.session_valid, phy.session_end, 1'b0, phy.vbus_valid};
    else if (hit(s_axi_araddr, OFS_PULL_CONTROL))
      rd_byte = pull_ctl_reg;
    else if (hit(s_axi_araddr, OFS_POWER_CONTROL))
      rd_byte = {sleep_guard_reg && activity_busy, 2'b00, sleep_guard_reg,
                 2'b00, suspend_reg, power_reg};
    else if (hit(s_axi_araddr, OFS_GEN_IRQ_STATUS))
      rd_byte = gen_flag_reg;
    else if (hit(s_axi_araddr, OFS_GEN_IRQ_ENABLE))
      rd_byte = gen_en_reg;
    else if (hit(s_axi_araddr, OFS_ERROR_FLAG_STATUS))
      rd_byte = err_flag_reg;
    else if (hit(s_axi_araddr, OFS_ERROR_FLAG_ENABLE))
      rd_byte = err_en_reg;
    else if (hit(s_axi_araddr, OFS_LAST_XFER_STATUS))
      rd_byte = {q_head.endpoint, q_head.tx, q_head.odd, 2'b00};
    else if (hit(s_axi_araddr, OFS_ROLE_CONTROL))
      rd_byte = role_reg;
    else
      rd_known = 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= s_axi_araddr[1] ? {8'h00, rd_byte, 16'h0000} : {24'h000000, rd_byte};
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: test/tb_usb_otg_status_error_power_regs.sv */
module tb_usb_otg_status_error_power_regs
  import uotgsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEADY = 20;
  logic clk = '0, rstn = '0, activity_busy = '0, suspend_hw_clear = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, xfer_ready;
  logic usb_clk_gate, xcvr_low_power, module_power_enable, host_role_enable, module_enable;
  logic frame_start_ev, bus_reset_ev, detach_ev, xfer_done;
  logic [7:0] gen_irq_status, rd_v, v, rnd = 8'h5c;
  uotgsr_err_ev_s err_ev;
  uotgsr_xfer_s xfer_info;
  uotgsr_phy_s phy;
  uotgsr_pull_s pulls;
  logic [5:0] xq[$];
  logic [7:0] ev_t[8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02};
  int pos_t[8] = '{7, 5, 4, 3, 2, 1, 0, 1};
  logic [11:0] zofs[6] = '{OFS_PULL_CONTROL, OFS_POWER_CONTROL, OFS_ERROR_FLAG_STATUS,
    OFS_ERROR_FLAG_ENABLE, OFS_LAST_XFER_STATUS, OFS_GEN_IRQ_ENABLE};
  int err_count = 0, num_checks = 0, cycles = 0;

  uotgsr_regs #(.STEADY_CYCLES(STEADY)) DUT (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .err_ev, .frame_start_ev, .bus_reset_ev,
    .detach_ev, .xfer_done, .xfer_info, .xfer_ready, .phy, .activity_busy, .suspend_hw_clear,
    .pulls, .usb_clk_gate, .xcvr_low_power, .module_power_enable, .host_role_enable,
    .module_enable, .gen_irq_status);
  uotgsr_far_model far (.clk, .xfer_ready, .err_ev, .frame_start_ev, .bus_reset_ev,
    .detach_ev, .xfer_done, .xfer_info, .phy);

  always #5 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    aw = '1;
    w = '1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {8'h00, d, 8'h00, d};
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        aw = '0;
        s_axi_awvalid <= '0;
      end
      if (w && s_axi_wready) begin
        w = '0;
        s_axi_wvalid <= '0;
      end
    end while (!(s_axi_bvalid && !aw && !w));
    s_axi_bready <= '0;
    chk("bresp", {6'h00, er}, {6'h00, s_axi_bresp});
  endtask

  task automatic rd(input logic [11:0] a);
    logic ar;
    ar = '1;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do begin
      @(posedge clk);
      if (ar && s_axi_arready) begin
        ar = '0;
        s_axi_arvalid <= '0;
      end
    end while (!(s_axi_rvalid && !ar));
    s_axi_rready <= '0;
    rd_v = a[1] ? s_axi_rdata[23:16] : s_axi_rdata[7:0];
    rsp = s_axi_rresp;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rd_v);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rstn <= '1;
    foreach (zofs[i])
      rdc(zofs[i], 8'h00);
    wr(OFS_ERROR_FLAG_ENABLE, 8'hbf, RESP_OKAY);
    wr(OFS_GEN_IRQ_ENABLE, 8'h0f, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      if (i == 7)
        wr(OFS_ROLE_CONTROL, 8'h08, RESP_OKAY);
      far.pulse(ev_t[i], 3'h0);
      v = 8'h01 << pos_t[i];
      rdc(OFS_ERROR_FLAG_STATUS, v);
      chk("summary", 8'h01, {7'h00, gen_irq_status[1]});
      wr(OFS_ERROR_FLAG_STATUS, v, RESP_OKAY);
      wr(OFS_GEN_IRQ_STATUS, 8'h02, RESP_OKAY);
      rdc(OFS_ERROR_FLAG_STATUS, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      if (i == 2)
        wr(OFS_ROLE_CONTROL, 8'h00, RESP_OKAY);
      far.pulse('0, 3'h1 << i);
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'h04;
      rdc(OFS_GEN_IRQ_STATUS, v);
      chk("general", v, gen_irq_status);
      wr(OFS_GEN_IRQ_STATUS, v, RESP_OKAY);
    end
    wr(OFS_ERROR_FLAG_ENABLE, 8'h00, RESP_OKAY);
    far.pulse(8'h81, 3'h0);
    rdc(OFS_ERROR_FLAG_STATUS, 8'h81);
    chk("summary", 8'h00, {7'h00, gen_irq_status[1]});
    wr(OFS_ERROR_FLAG_STATUS, 8'h80, RESP_OKAY);
    rdc(OFS_ERROR_FLAG_STATUS, 8'h01);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      v = (rnd & PC_IMPL_MASK) | 8'h04;
      wr(OFS_PULL_CONTROL, v, RESP_OKAY);
      rdc(OFS_PULL_CONTROL, v);
      chk("pulls", {v[7:4], 3'h0, v[0]}, {pulls[4:1], 3'h0, pulls[0]});
    end
    wr(OFS_PULL_CONTROL, 8'h00, RESP_OKAY);
    wr(OFS_ROLE_CONTROL, 8'h01, RESP_OKAY);
    chk("pulls", 8'h10, {3'h0, pulls});
    wr(OFS_ROLE_CONTROL, 8'h09, RESP_OKAY);
    chk("pulls", 8'h06, {3'h0, pulls});
    chk("roles", 8'h03, {6'h00, host_role_enable, module_enable});
    wr(OFS_ROLE_CONTROL, 8'h00, RESP_OKAY);
    activity_busy <= '1;
    wr(OFS_POWER_CONTROL, 8'h13, RESP_OKAY);
    rdc(OFS_POWER_CONTROL, 8'h93);
    chk("power", 8'h07, {5'h00, usb_clk_gate, xcvr_low_power, module_power_enable});
    suspend_hw_clear <= '1;
    @(posedge clk);
    suspend_hw_clear <= '0;
    activity_busy <= '0;
    rdc(OFS_POWER_CONTROL, 8'h11);
    wr(OFS_POWER_CONTROL, 8'h00, RESP_OKAY);
    for (int i = 0; i < XFER_QUEUE_DEPTH; i++) begin
      rnd = lfsr(rnd);
      xq.push_back(rnd[5:0]);
      far.send_xfer(rnd[5:0]);
    end
    @(posedge clk);
    chk("ready", 8'h00, {7'h00, xfer_ready});
    while (xq.size() > 0) begin
      rdc(OFS_LAST_XFER_STATUS, {xq[0], 2'h0});
      chk("token", 8'h01, {7'h00, gen_irq_status[3]});
      wr(OFS_GEN_IRQ_STATUS, 8'h08, RESP_OKAY);
      void'(xq.pop_front());
    end
    chk("token", 8'h00, {7'h00, gen_irq_status[3]});
    rdc(OFS_LAST_XFER_STATUS, 8'h00);
    far.set_phy(6'h35);
    repeat (STEADY + 5) @(posedge clk);
    rdc(OFS_LINE_STATUS, 8'ha9);
    far.set_phy(6'h0c);
    rdc(OFS_LINE_STATUS, 8'h05);
    wr(12'h700, 8'hff, RESP_SLVERR);
    rd(12'h700);
    chk("rresp", {6'h00, RESP_SLVERR}, {6'h00, rsp});
    results();
  end
endmodule

/* File: test/uotgsr_far_model.sv */
module uotgsr_far_model
  import uotgsr_pkg::*;
(
  input wire logic clk,
  input wire logic xfer_ready,
  output uotgsr_err_ev_s err_ev,
  output logic frame_start_ev,
  output logic bus_reset_ev,
  output logic detach_ev,
  output logic xfer_done,
  output uotgsr_xfer_s xfer_info,
  output uotgsr_phy_s phy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    err_ev = '0;
    {frame_start_ev, bus_reset_ev, detach_ev, xfer_done} = '0;
    xfer_info = '0;
    phy = '0;
  end
  task automatic pulse(input uotgsr_err_ev_s e, input logic [2:0] g);
    @(posedge clk);
    err_ev <= e;
    {frame_start_ev, bus_reset_ev, detach_ev} <= g;
    @(posedge clk);
    err_ev <= '0;
    {frame_start_ev, bus_reset_ev, detach_ev} <= '0;
  endtask
  // Idle info is scrambled so nobody leans on a stale value
  task automatic send_xfer(input uotgsr_xfer_s x);
    int n;
    n = 0;
    @(posedge clk);
    xfer_info <= x;
    xfer_done <= '1;
    do begin
      @(posedge clk);
      n++;
    end while (!xfer_ready && n < 50);
    xfer_done <= '0;
    xfer_info <= ~x;
  endtask
  task automatic set_phy(input uotgsr_phy_s p);
    @(posedge clk);
    phy <= p;
  endtask
endmodule

/* File: test/uotgsr_regs_asserts.sv */
module uotgsr_asserts
  import uotgsr_pkg::*;
#(
  parameter int STEADY_CYCLES = LINE_STEADY_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire uotgsr_err_ev_s err_ev,
  input wire logic xfer_done,
  input wire logic xfer_ready,
  input wire uotgsr_phy_s phy,
  input wire logic suspend_hw_clear,
  input wire logic usb_clk_gate,
  input wire logic xcvr_low_power,
  input wire logic [7:0] gen_irq_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] rd_addr;
  logic [1:0] line_reg;
  int stable_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_addr <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  // Margin of a few cycles below: the exact counter phase is the design's choice
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_reg <= '0;
      stable_cnt <= 0;
    end else begin
      line_reg <= {phy.line_se0, phy.line_j};
      stable_cnt <= (line_reg != {phy.line_se0, phy.line_j}) ? 0 : stable_cnt + 1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence rd_done(logic [11:0] a);
    $rose(s_axi_rvalid) && rd_addr == a;
  endsequence
  AST_SUSPEND_PAIR: assert property (usb_clk_gate == xcvr_low_power)
    else $error("clock gate and transceiver state disagree");
  AST_HW_CLEAR: assert property (suspend_hw_clear |=> !usb_clk_gate)
    else $error("suspend survived a hardware clear");
  AST_SUMMARY_CAUSE:
    assert property ($rose(gen_irq_status[1]) |-> $past(|err_ev) || $rose(s_axi_bvalid))
    else $error("summary error raised without an error event");
  AST_SUMMARY_HOLD: assert property ($fell(gen_irq_status[1]) |-> $rose(s_axi_bvalid))
    else $error("summary error dropped without a write");
  AST_READY_DROP: assert property ($fell(xfer_ready) |-> $past(xfer_done))
    else $error("queue filled without a transfer");
  AST_IDENT:
    assert property (rd_done(OFS_LINE_STATUS) |-> s_axi_rdata[7] == phy.cable_ident)
    else $error("cable ident bit wrong");
  AST_VBUS:
    assert property (rd_done(OFS_LINE_STATUS) |-> {s_axi_rdata[3], s_axi_rdata[2],
      s_axi_rdata[0]} == {phy.session_valid, phy.session_end, phy.vbus_valid})
    else $error("bus voltage indicators wrong");
  AST_STEADY:
    assert property (rd_done(OFS_LINE_STATUS) |-> (s_axi_rdata[5] ?
      $past(stable_cnt) >= STEADY_CYCLES - 3 : $past(stable_cnt) <= STEADY_CYCLES + 3))
    else $error("line steady bit disagrees with line history");
  AST_PULL_RSVD:
    assert property (rd_done(OFS_PULL_CONTROL) |-> !s_axi_rdata[19] && !s_axi_rdata[17])
    else $error("reserved pull control bit read as one");
endmodule

bind uotgsr_regs uotgsr_asserts #(.STEADY_CYCLES(STEADY_CYCLES)) u_chk (.clk, .rstn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid,
  .err_ev, .xfer_done, .xfer_ready, .phy, .suspend_hw_clear, .usb_clk_gate, .xcvr_low_power,
  .gen_irq_status);
